// ---- logic/slot_operation_status.sv ----
// Overview of operation
// RL1: Keep live condition word per slot, readable
// RL2: Condition word bits 15:8 and 2 zero
// RL3: Bit 4 follows shutter open
// RL4: Bit 3 high while zeroing runs
// RL5: Bit 1 follows coherence control active
// RL6: Bit 0 follows laser on
// RL7: Bits 7:5 used only for attenuators
// RL8: Bit 5 follows offset feature enabled
// RL9: Bits 7:6 encode offset source type
// RL10: Controller writes mask up to 32767; stored
// RL11: Mask one passes event bit, zero blocks
// RL12: Slot n result drives summary bit n
// RL13: Per-slot event register, same layout as condition
// RL14: Mask read-back query returns stored mask
// RL15: Summary bit is OR of event AND mask
// RL16: Event latches on rising condition; read clears
`timescale 1ns/10ps
module slot_operation_status (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic [15:0] i_laser_on,
  input  wire logic [15:0] i_coherence_on,
  input  wire logic [15:0] i_zeroing,
  input  wire logic [15:0] i_shutter_open,
  input  wire logic [15:0] i_offset_enabled,
  input  wire logic [15:0] i_offset_type1,
  input  wire logic [15:0] i_offset_type2,
  input  wire logic [15:0] i_is_attenuator,
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd_code,
  input  wire logic [3:0]  i_cmd_slot,
  input  wire logic [15:0] i_cmd_data,
  output logic             o_rsp_valid,
  output logic      [15:0] o_rsp_data,
  output logic      [15:0] o_op_event_summary
);

  typedef struct packed {
    logic        rsp_valid;
    logic [15:0] rsp_data;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  logic [15:0][15:0] slot_cond;
  logic [15:0][15:0] slot_event;
  logic [15:0][15:0] slot_mask;
  logic [15:0]       slot_summary;
  logic [15:0]       slot_sel;
  logic              is_write;
  logic              is_event_read;

  assign is_write      = i_cmd_valid && (i_cmd_code == slot_status_pkg::CMD_WRITE_MASK);
  assign is_event_read = i_cmd_valid && (i_cmd_code == slot_status_pkg::CMD_READ_EVENT);

  genvar n;
  generate
    for (n = 0; n < slot_status_pkg::NUM_SLOTS; n = n + 1) begin : g_slot
      logic [7:0] raw;
      assign slot_sel[n] = (i_cmd_slot == 4'(n));
      assign raw = {i_offset_type2[n], i_offset_type1[n], i_offset_enabled[n], i_shutter_open[n],
                    i_zeroing[n], 1'b0, i_coherence_on[n], i_laser_on[n]};
      slot_status_unit u_slot (
        .i_clock         (i_clock),
        .i_srst          (i_srst),
        .i_status_raw    (raw),
        .i_is_attenuator (i_is_attenuator[n]),
        .i_mask_wr       (is_write && slot_sel[n]),       // RL10
        .i_mask_data     (i_cmd_data),
        .i_event_clr     (is_event_read && slot_sel[n]),  // RL16
        .o_condition     (slot_cond[n]),
        .o_event         (slot_event[n]),
        .o_mask          (slot_mask[n]),
        .o_summary       (slot_summary[n])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    if (i_cmd_valid) begin
      case (i_cmd_code)
        slot_status_pkg::CMD_READ_CONDITION: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = slot_cond[i_cmd_slot]; // RL1
        end
        slot_status_pkg::CMD_READ_EVENT: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = slot_event[i_cmd_slot]; // RL13
        end
        slot_status_pkg::CMD_READ_MASK: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = slot_mask[i_cmd_slot]; // RL14
        end
        slot_status_pkg::CMD_READ_SUMMARY: begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = slot_summary; // RL12
        end
        default: begin
          // Writes and unknown codes give no answer
          state_next.rsp_valid = 1'b0;
        end
      endcase
    end
    if (i_srst) begin
      state_next.rsp_valid = 1'b0;
      state_next.rsp_data  = slot_status_pkg::DATA_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    state_reg <= state_next;
  end

  assign o_rsp_valid        = state_reg.rsp_valid;
  assign o_rsp_data         = state_reg.rsp_data;
  assign o_op_event_summary = slot_summary; // RL12
endmodule

// ---- include/slot_status_pkg.sv ----
package slot_status_pkg;

  localparam int unsigned NUM_SLOTS   = 16;
  localparam int unsigned SLOT_BITS   = 4;
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned STATUS_BITS = 8;

  // Condition / event bit positions
  localparam int unsigned BIT_LASER_ON     = 0;
  localparam int unsigned BIT_COHERENCE_ON = 1;
  localparam int unsigned BIT_UNUSED_2     = 2;
  localparam int unsigned BIT_ZEROING      = 3;
  localparam int unsigned BIT_SHUTTER_OPEN = 4;
  localparam int unsigned BIT_OFFSET_EN    = 5;
  localparam int unsigned BIT_OFFSET_TYPE1 = 6;
  localparam int unsigned BIT_OFFSET_TYPE2 = 7;

  // Bits that may ever be one in a condition word
  localparam logic [15:0] COND_USED_MASK  = 16'h00FB;
  // Largest value the mask may hold
  localparam logic [15:0] MASK_LEGAL_MASK = 16'h7FFF;

  localparam logic [15:0] MASK_RESET  = 16'h0000;
  localparam logic [15:0] COND_RESET  = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET  = 16'h0000;

  // Command codes of the controller port
  localparam logic [2:0] CMD_READ_CONDITION = 3'h0;
  localparam logic [2:0] CMD_READ_EVENT     = 3'h1;
  localparam logic [2:0] CMD_WRITE_MASK     = 3'h2;
  localparam logic [2:0] CMD_READ_MASK      = 3'h3;
  localparam logic [2:0] CMD_READ_SUMMARY   = 3'h4;

endpackage

// ---- logic/slot_status_unit.sv ----
`timescale 1ns/10ps
module slot_status_unit (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_status_raw,
  input  wire logic        i_is_attenuator,
  input  wire logic        i_mask_wr,
  input  wire logic [15:0] i_mask_data,
  input  wire logic        i_event_clr,
  output logic      [15:0] o_condition,
  output logic      [15:0] o_event,
  output logic      [15:0] o_mask,
  output logic             o_summary
);

  typedef struct packed {
    logic [8:0]  sync1;
    logic [8:0]  sync2;
    logic [15:0] cond;
    logic [15:0] event_bits;
    logic [15:0] mask;
    logic        summary;
  } slot_state_t;

  slot_state_t state_reg;
  slot_state_t state_next;

  always_comb begin
    logic [15:0] cond_w;
    logic        atten;
    cond_w     = slot_status_pkg::COND_RESET;
    atten      = 1'b0;
    state_next = state_reg;
    state_next.sync1 = {i_is_attenuator, i_status_raw};
    state_next.sync2 = state_reg.sync1;
    atten = state_reg.sync2[8];
    cond_w[slot_status_pkg::BIT_LASER_ON]     = state_reg.sync2[slot_status_pkg::BIT_LASER_ON];     // RL6
    cond_w[slot_status_pkg::BIT_COHERENCE_ON] = state_reg.sync2[slot_status_pkg::BIT_COHERENCE_ON]; // RL5
    cond_w[slot_status_pkg::BIT_ZEROING]      = state_reg.sync2[slot_status_pkg::BIT_ZEROING];      // RL4
    cond_w[slot_status_pkg::BIT_SHUTTER_OPEN] = state_reg.sync2[slot_status_pkg::BIT_SHUTTER_OPEN]; // RL3
    // Offset bits only for attenuators; type is meaningless while disabled
    cond_w[slot_status_pkg::BIT_OFFSET_EN] = atten & state_reg.sync2[slot_status_pkg::BIT_OFFSET_EN]; // RL7 RL8
    cond_w[slot_status_pkg::BIT_OFFSET_TYPE1] = cond_w[slot_status_pkg::BIT_OFFSET_EN]
                                                & state_reg.sync2[slot_status_pkg::BIT_OFFSET_TYPE1]; // RL9
    cond_w[slot_status_pkg::BIT_OFFSET_TYPE2] = cond_w[slot_status_pkg::BIT_OFFSET_EN]
                                                & state_reg.sync2[slot_status_pkg::BIT_OFFSET_TYPE2]; // RL9
    state_next.cond = cond_w & slot_status_pkg::COND_USED_MASK; // RL1 RL2
    // Set wins over a read clear in the same cycle
    state_next.event_bits = (i_event_clr ? slot_status_pkg::EVENT_RESET : state_reg.event_bits)
                            | (state_next.cond & ~state_reg.cond); // RL13 RL16
    if (i_mask_wr) begin
      state_next.mask = i_mask_data & slot_status_pkg::MASK_LEGAL_MASK; // RL10
    end
    state_next.summary = |(state_next.event_bits & state_next.mask); // RL11 RL15
    if (i_srst) begin
      state_next = '0;
      state_next.cond       = slot_status_pkg::COND_RESET;
      state_next.event_bits = slot_status_pkg::EVENT_RESET;
      state_next.mask       = slot_status_pkg::MASK_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    state_reg <= state_next;
  end

  assign o_condition = state_reg.cond;
  assign o_event     = state_reg.event_bits;
  assign o_mask      = state_reg.mask;
  assign o_summary   = state_reg.summary;

endmodule

// ---- verif/slot_status_properties.sv ----
`timescale 1ns/10ps
module slot_status_properties (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_cmd_valid,
  input wire logic [2:0]  i_cmd_code,
  input wire logic [3:0]  i_cmd_slot,
  input wire logic [15:0] i_cmd_data,
  input wire logic        o_rsp_valid,
  input wire logic [15:0] o_rsp_data,
  input wire logic [15:0] o_op_event_summary
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic rd;
  logic wr;
  assign rd = i_cmd_valid && i_cmd_code != 3'h2 && i_cmd_code < 3'h5;
  assign wr = i_cmd_valid && i_cmd_code == 3'h2;
  a_read_answers: assert property (rd |=> o_rsp_valid) else $error("no answer");
  a_no_stray: assert property (!rd |=> !o_rsp_valid) else $error("stray answer");
  // Skip the edge after reset, where the data was just cleared
  a_data_holds: assert property (!o_rsp_valid && !$past(i_srst) |-> $stable(o_rsp_data))
    else $error("data moved");
  a_unused_zero: assert property (o_rsp_valid && $past(i_cmd_code) < 3'h2
    |-> o_rsp_data[15:8] == 8'h00 && !o_rsp_data[2]) else $error("unused bit set");
  a_mask_top: assert property (o_rsp_valid && $past(i_cmd_code) == 3'h3 |-> !o_rsp_data[15])
    else $error("mask bit 15 set");
  a_mask_readback: assert property (wr ##1 !i_cmd_valid ##1 rd && i_cmd_code == 3'h3
    && i_cmd_slot == $past(i_cmd_slot, 2) |=> o_rsp_data == ($past(i_cmd_data, 3) & 16'h7fff))
    else $error("mask readback");
  a_mask_blocks: assert property (wr && i_cmd_data == 16'h0000
    |=> !o_op_event_summary[$past(i_cmd_slot)]) else $error("masked event leaked");
  a_reset_quiet: assert property (disable iff (1'b0) i_srst |=> !o_rsp_valid && o_op_event_summary == 16'h0000)
    else $error("reset left output");
  c_mask_read: cover property (rd && i_cmd_code == 3'h3);
  c_event_seen: cover property (o_rsp_valid && $past(i_cmd_code) == 3'h1 && o_rsp_data != 16'h0000);
  c_summary_set: cover property (o_op_event_summary != 16'h0000);
endmodule

// ---- verif/host_model.sv ----
`timescale 1ns/10ps
module host_model (
  input  wire logic        i_clock,
  output logic             o_cmd_valid,
  output logic      [2:0]  o_cmd_code,
  output logic      [3:0]  o_cmd_slot,
  output logic      [15:0] o_cmd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 3'h7;
    o_cmd_slot = 4'h0;
    o_cmd_data = 16'h0000;
  end
  // A nonzero gap models a slow controller
  task automatic send(input logic [2:0] c, input logic [3:0] s, input logic [15:0] d, input int gap);
    repeat (gap + 1) @(negedge i_clock);
    o_cmd_valid = 1'b1;
    o_cmd_code = c;
    o_cmd_slot = s;
    o_cmd_data = d & 16'h7fff;
    @(negedge i_clock);
    o_cmd_valid = 1'b0;
    // Idle slot and data fields carry junk so nothing leans on stale values
    o_cmd_data = ~o_cmd_data;
    o_cmd_slot = ~o_cmd_slot;
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        clock, srst, valid, rsp_valid;
  logic [2:0]  code;
  logic [3:0]  slot, s;
  logic [15:0] data, rsp_data, summary, v, d;
  logic [15:0] p [8];
  logic [31:0] seed = 32'h0000_6719;
  int          mismatches, total_checks;
  host_model i_host (.i_clock(clock), .o_cmd_valid(valid), .o_cmd_code(code), .o_cmd_slot(slot), .o_cmd_data(data));
  slot_operation_status i_dut (.i_clock(clock), .i_srst(srst), .i_laser_on(p[0]), .i_coherence_on(p[1]),
    .i_zeroing(p[2]), .i_shutter_open(p[3]), .i_offset_enabled(p[4]), .i_offset_type1(p[5]),
    .i_offset_type2(p[6]), .i_is_attenuator(p[7]), .i_cmd_valid(valid), .i_cmd_code(code), .i_cmd_slot(slot),
    .i_cmd_data(data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_op_event_summary(summary));
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] exp_cond(input logic [3:0] n);
    logic en;
    en = p[7][n] & p[4][n];
    return {8'h00, en & p[6][n], en & p[5][n], en, p[3][n], p[2][n], 1'b0, p[1][n], p[0][n]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic [3:0] n, input logic [15:0] w);
    i_host.send(c, n, w, 0);
    chk({15'h0000, rsp_valid}, {15'h0000, c != 3'h2 && c < 3'h5});
    v = rsp_data;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    foreach (p[k]) p[k] = 16'h0000;
    // Count rising edges; the clock's first step from unknown is a falling one
    repeat (3) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    chk(summary, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      foreach (p[k]) p[k] = xs();
      // First rounds walk every offset source code
      if (i < 4) {p[7], p[4], p[6], p[5]} = {32'hffff_ffff, {16{i[1]}}, {16{i[0]}}};
      repeat (4) @(negedge clock);
      s = 4'(xs());
      cmd(3'h0, s, 16'h0000);
      chk(v, exp_cond(s));
      d = xs();
      cmd(3'h2, s, d);
      cmd(3'h3, s, 16'h0000);
      chk(v, d & 16'h7fff);
    end
    foreach (p[k]) p[k] = 16'h0000;
    repeat (4) @(negedge clock);
    for (int n = 0; n < 16; n++) begin
      cmd(3'h1, 4'(n), 16'h0000);
    end
    chk(summary, 16'h0000);
    cmd(3'h2, 4'h5, 16'h0010);
    p[3][5] = 1'b1;
    repeat (4) @(negedge clock);
    chk(summary, 16'h0020);
    cmd(3'h4, 4'h0, 16'h0000);
    chk(v, 16'h0020);
    // Unknown code must neither answer nor clear the pending event
    cmd(3'h5, 4'h5, 16'h0000);
    cmd(3'h1, 4'h5, 16'h0000);
    chk(v, 16'h0010);
    chk(summary, 16'h0000);
    p[3][5] = 1'b0;
    cmd(3'h2, 4'h5, 16'h7fef);
    repeat (4) @(negedge clock);
    p[3][5] = 1'b1;
    repeat (4) @(negedge clock);
    chk(summary, 16'h0000);
    cmd(3'h1, 4'h5, 16'h0000);
    chk(v, 16'h0010);
    // Mid-run reset: masks clear, a still-open shutter latches again
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    cmd(3'h3, 4'h5, 16'h0000);
    chk(v, 16'h0000);
    cmd(3'h1, 4'h5, 16'h0000);
    chk(v, 16'h0010);
    chk(summary, 16'h0000);
    cmd(3'h2, 4'h5, 16'h0000);
    complete_run();
  end
endmodule
bind slot_operation_status slot_status_properties i_props (.*);
